// ==== verilog/move_ops_pkg.sv ====
package move_ops_pkg;
   // instruction word layout
   localparam int INSN_W = 12;
   localparam int DATA_W = 8;
   localparam int FR_ADDR_W = 5;
   localparam int PTR_W = 8;
   localparam int PORT_SEL_W = 4;
   // opcode patterns
   localparam logic [6:0] STORE_ACC_TOP = 7'h01; // 0000 001f ffff
   localparam logic [7:0] LIT_PTR_TOP = 8'h05; // 0000 0101 kkkk
   localparam logic [11:0] ACC_PTR_OP = 12'h043; // 0000 0100 0011
   localparam logic [7:0] CTRL_XFER_TOP = 8'h00; // 0000 0000 ffff
   // port select field range
   localparam logic [3:0] PORT_FIRST = 4'h5;
   localparam logic [3:0] PORT_LAST = 4'h9;
   // reset values
   localparam logic [7:0] PTR_RST = 8'h00;
   // pointer field positions
   localparam int LIT_W = 4;
   localparam int WIDE_W = 5;
   // one instruction cycle per move
   localparam int MOVE_CYCLES = 1;
endpackage

// ==== verilog/move_decode.sv ====
// opcode match for the three moves and the control transfer
module move_decode
   import move_ops_pkg::*;
(
   input wire logic [INSN_W-1:0] insn, // instruction word
   input wire logic insn_valid, // word is executing this cycle
   output logic is_store_acc, // accumulator to file register
   output logic is_lit_ptr, // literal to pointer
   output logic is_acc_ptr, // accumulator to pointer
   output logic is_ctrl_xfer // control-register transfer
);
   wire port_in_range;

   // pattern compares
   assign port_in_range = (insn[3:0] >= PORT_FIRST) &&
                          (insn[3:0] <= PORT_LAST);
   assign is_store_acc = insn_valid && (insn[11:5] == STORE_ACC_TOP);
   assign is_lit_ptr = insn_valid && (insn[11:4] == LIT_PTR_TOP);
   assign is_acc_ptr = insn_valid && (insn == ACC_PTR_OP);
   assign is_ctrl_xfer = insn_valid && (insn[11:4] == CTRL_XFER_TOP) &&
                         port_in_range;
endmodule

// ==== verilog/accumulator_move_ops.sv ====
// Behaviour
// - store accumulator into addressed file register
// - literal nibble loads pointer low four bits
// - narrow: accumulator low four bits to pointer
// - wide: accumulator low five bits to pointer
// - wide literal load keeps pointer bit four
// - pointer selects control register for transfers
// - port from field 5..9; pointer picks register
module accumulator_move_ops
   import move_ops_pkg::*;
#(
   parameter bit WIDE_CFG = 1'b0 // 1: five-bit pointer devices
)(
   input wire logic clk_sys, // instruction clock
   input wire logic sys_rst, // synchronous reset, high
   input wire logic [move_ops_pkg::INSN_W-1:0] insn, // executing word
   input wire logic insn_valid, // word executes this cycle
   input wire logic [move_ops_pkg::DATA_W-1:0] acc, // accumulator value
   output logic fr_we, // file register write strobe
   output logic [move_ops_pkg::FR_ADDR_W-1:0] fr_addr, // file reg address
   output logic [move_ops_pkg::DATA_W-1:0] fr_wdata, // file reg data
   output logic acc_we, // accumulator write, never set
   output logic status_we, // status flag write, never set
   output logic [move_ops_pkg::PTR_W-1:0] ptr, // pointer register
   output logic ctrl_xfer, // control transfer strobe
   output logic [move_ops_pkg::PORT_SEL_W-1:0] ctrl_port, // port field
   output logic [move_ops_pkg::PTR_W-1:0] ctrl_reg_sel // pointer snapshot
);
   import move_ops_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks: field slicing below relies on these shapes
   if (INSN_W != 12) begin : g_chk_insn
      $error("instruction word must be twelve bits wide");
   end
   if (DATA_W != 8) begin : g_chk_acc
      $error("accumulator must be eight bits wide");
   end
   if (FR_ADDR_W != 5) begin : g_chk_addr
      $error("store operand field must be five bits wide");
   end
   if (PORT_SEL_W != LIT_W) begin : g_chk_port
      $error("port field and literal share the low nibble");
   end
   if (WIDE_W <= LIT_W) begin : g_chk_wide
      $error("wide pointer field must exceed the literal field");
   end
   if (PTR_W <= WIDE_W) begin : g_chk_ptr
      $error("pointer must be wider than its loaded field");
   end
   if (DATA_W < WIDE_W) begin : g_chk_data
      $error("accumulator narrower than the wide pointer field");
   end
   if (PORT_FIRST > PORT_LAST) begin : g_chk_range
      $error("port field range is empty");
   end
   if (MOVE_CYCLES != 1) begin : g_chk_cycles
      $error("moves are built as single cycle operations");
   end

   ////////////////////////////////////////////////////////////////////////
   // decode results
   wire is_store_acc;
   wire is_lit_ptr;
   wire is_acc_ptr;
   wire is_ctrl_xfer;
   wire ptr_load; // either pointer load this cycle

   // pointer state and candidates
   logic [PTR_W-1:0] ptr_ff;
   logic [PTR_W-1:0] nxt_ptr;
   wire [PTR_W-1:0] lit_ptr;
   wire [PTR_W-1:0] acc_ptr_narrow;
   wire [PTR_W-1:0] acc_ptr_wide;
   wire [PTR_W-1:0] acc_ptr;
   wire [PTR_W-1:0] load_ptr;

   // file register write state
   logic fr_we_ff;
   logic nxt_fr_we;
   logic [FR_ADDR_W-1:0] fr_addr_ff;
   logic [FR_ADDR_W-1:0] nxt_fr_addr;
   logic [DATA_W-1:0] fr_wdata_ff;
   logic [DATA_W-1:0] nxt_fr_wdata;

   // control transfer state
   logic ctrl_xfer_ff;
   logic nxt_ctrl_xfer;
   logic [PORT_SEL_W-1:0] ctrl_port_ff;
   logic [PORT_SEL_W-1:0] nxt_ctrl_port;
   logic [PTR_W-1:0] ctrl_reg_sel_ff;
   logic [PTR_W-1:0] nxt_ctrl_reg_sel;

   // opcode decode, purely combinational
   move_decode u_dec (
      .insn(insn),
      .insn_valid(insn_valid),
      .is_store_acc(is_store_acc),
      .is_lit_ptr(is_lit_ptr),
      .is_acc_ptr(is_acc_ptr),
      .is_ctrl_xfer(is_ctrl_xfer)
   );

   ////////////////////////////////////////////////////////////////////////
   // timing overview:
   // - word taken on the edge with insn_valid high
   // - effect visible on registered outputs one cycle later
   // - transfer right after a load sees the new pointer
   // - transfer and load in one word cannot both decode
   // - accumulator and status flags never written here

   ////////////////////////////////////////////////////////////////////////
   // pointer candidates; bits above the written field are kept
   assign lit_ptr = {ptr_ff[PTR_W-1:LIT_W],
                     insn[LIT_W-1:0]};
   assign acc_ptr_narrow = {ptr_ff[PTR_W-1:LIT_W],
                            acc[LIT_W-1:0]};
   assign acc_ptr_wide = {ptr_ff[PTR_W-1:WIDE_W],
                          acc[WIDE_W-1:0]};

   // configuration picks how much of the accumulator lands
   assign acc_ptr = WIDE_CFG ? acc_ptr_wide : acc_ptr_narrow;

   // the two load forms never match the same word
   assign load_ptr = is_lit_ptr ? lit_ptr : acc_ptr;
   assign ptr_load = is_lit_ptr || is_acc_ptr;

   // hold unless a load is decoded this cycle
   assign nxt_ptr = ptr_load ? load_ptr : ptr_ff;

   // pointer register, updated on the taking edge
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ptr_ff <= PTR_RST;
      end else begin
         ptr_ff <= nxt_ptr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // store: strobe for one cycle, address and data held after
   assign nxt_fr_we = is_store_acc;
   assign nxt_fr_addr = is_store_acc ? insn[FR_ADDR_W-1:0]
                                     : fr_addr_ff;
   assign nxt_fr_wdata = is_store_acc ? acc : fr_wdata_ff;

   // file register write strobe
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fr_we_ff <= 1'b0;
      end else begin
         fr_we_ff <= nxt_fr_we;
      end
   end

   // file register address and data
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fr_addr_ff <= '0;
         fr_wdata_ff <= '0;
      end else begin
         fr_addr_ff <= nxt_fr_addr;
         fr_wdata_ff <= nxt_fr_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transfer: current pointer picks register and access kind
   assign nxt_ctrl_xfer = is_ctrl_xfer;
   assign nxt_ctrl_port = is_ctrl_xfer ? insn[PORT_SEL_W-1:0]
                                       : ctrl_port_ff;
   assign nxt_ctrl_reg_sel = is_ctrl_xfer ? ptr_ff
                                          : ctrl_reg_sel_ff;

   // transfer strobe
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_xfer_ff <= 1'b0;
      end else begin
         ctrl_xfer_ff <= nxt_ctrl_xfer;
      end
   end

   // port field and pointer snapshot
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_port_ff <= '0;
         ctrl_reg_sel_ff <= PTR_RST;
      end else begin
         ctrl_port_ff <= nxt_ctrl_port;
         ctrl_reg_sel_ff <= nxt_ctrl_reg_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // moves never write accumulator or flags
   assign acc_we = 1'b0;
   assign status_we = 1'b0;

   // pointer seen as is; access kind decoded downstream
   assign ptr = ptr_ff;

   // file register write port
   assign fr_we = fr_we_ff;
   assign fr_addr = fr_addr_ff;
   assign fr_wdata = fr_wdata_ff;

   // control transfer port
   assign ctrl_xfer = ctrl_xfer_ff;
   assign ctrl_port = ctrl_port_ff;
   assign ctrl_reg_sel = ctrl_reg_sel_ff;
endmodule

// ==== tb/move_ops_assertions.sv ====
module move_ops_chk
   import move_ops_pkg::*;
#(parameter bit WIDE_CFG = 1'b0)(
   input wire logic clk_sys, sys_rst, insn_valid, // clock, reset, valid
   input wire logic fr_we, acc_we, status_we, ctrl_xfer, // strobes
   input wire logic [11:0] insn, // word
   input wire logic [7:0] acc, fr_wdata, ptr, ctrl_reg_sel, // data
   input wire logic [4:0] fr_addr, // address
   input wire logic [3:0] ctrl_port // port
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // opcode matches
   wire st = insn_valid && insn[11:5] == STORE_ACC_TOP;
   wire lp = insn_valid && insn[11:4] == LIT_PTR_TOP;
   wire ap = insn_valid && insn == ACC_PTR_OP;
   wire cx = insn_valid && insn[11:4] == CTRL_XFER_TOP
      && insn[3:0] >= PORT_FIRST && insn[3:0] <= PORT_LAST;
   // one cycle after the taking edge
   property p_st; st |=> fr_we && fr_wdata == $past(acc)
      && fr_addr == $past(insn[4:0]); endproperty
   a_st: assert property (p_st) else $error("store");
   property p_lit; lp |=> ptr[3:0] == $past(insn[3:0]); endproperty
   a_lit: assert property (p_lit) else $error("lit");
   property p_acc; ap |=> ptr[3:0] == $past(acc[3:0]); endproperty
   a_acc: assert property (p_acc) else $error("acc");
   property p_wide; ap && WIDE_CFG |=> ptr[4] == $past(acc[4]); endproperty
   a_wide: assert property (p_wide) else $error("wide");
   property p_keep; lp |=> ptr[7:4] == $past(ptr[7:4]); endproperty
   a_keep: assert property (p_keep) else $error("keep");
   property p_sel; cx |=> ctrl_xfer && ctrl_reg_sel == $past(ptr); endproperty
   a_sel: assert property (p_sel) else $error("sel");
   property p_port; cx |=> ctrl_port == $past(insn[3:0]); endproperty
   a_port: assert property (p_port) else $error("port");
   property p_flag; st || lp || ap |=> !acc_we && !status_we; endproperty
   a_flag: assert property (p_flag) else $error("flag");
   c_st: cover property (st);
   c_lp: cover property (lp);
   c_ap: cover property (ap);
   c_cx: cover property (cx);
endmodule
bind accumulator_move_ops move_ops_chk #(.WIDE_CFG(WIDE_CFG)) u_chk (.*);

// ==== tb/test_accumulator_move_ops.sv ====
module test_accumulator_move_ops;
   timeunit 1ns;
   timeprecision 1ns;
   import move_ops_pkg::*;
   logic clk_sys = 1'b0, sys_rst = 1'b1, insn_valid = 1'b0;
   logic fr_we, acc_we, status_we, ctrl_xfer;
   logic fr_we_n, acc_we_n, status_we_n, ctrl_xfer_n;
   logic [11:0] insn = '0, rw;
   logic [7:0] acc = '0, ptr, fr_wdata, ctrl_reg_sel, m_ptr = '0;
   logic [7:0] ptr_n, fr_wdata_n, ctrl_reg_sel_n, m_ptr_n = '0;
   logic [4:0] fr_addr, fr_addr_n;
   logic [3:0] ctrl_port, ctrl_port_n;
   logic [31:0] r = 32'h2221C086;
   int error_cnt = 0, n_tests = 0;
   // wide configuration
   accumulator_move_ops #(.WIDE_CFG(1'b1)) u_dut (.*);
   // narrow configuration on the same stimulus
   accumulator_move_ops #(.WIDE_CFG(1'b0)) u_narrow (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .insn(insn),
      .insn_valid(insn_valid),
      .acc(acc),
      .fr_we(fr_we_n),
      .fr_addr(fr_addr_n),
      .fr_wdata(fr_wdata_n),
      .acc_we(acc_we_n),
      .status_we(status_we_n),
      .ptr(ptr_n),
      .ctrl_xfer(ctrl_xfer_n),
      .ctrl_port(ctrl_port_n),
      .ctrl_reg_sel(ctrl_reg_sel_n)
   );
   initial forever #20 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [12:0] e, g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %0h got %0h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one word, then outputs against the pointer model
   task automatic step(input logic [11:0] w, input logic [7:0] a);
      logic s, x;
      logic [3:0] sw, sn;
      s = w[11:5] == STORE_ACC_TOP;
      x = w[11:4] == 8'h00 && w[3:0] >= PORT_FIRST && w[3:0] <= PORT_LAST;
      @(posedge clk_sys);
      insn <= w;
      acc <= a;
      insn_valid <= 1'b1;
      @(posedge clk_sys);
      insn_valid <= 1'b0;
      #1;
      sw = {fr_we, ctrl_xfer, acc_we, status_we};
      sn = {fr_we_n, ctrl_xfer_n, acc_we_n, status_we_n};
      chk("strobes", {s, x, 2'h0}, sw);
      chk("strobes_n", {s, x, 2'h0}, sn);
      if (s) chk("store", {w[4:0], a}, {fr_addr, fr_wdata});
      if (s) chk("store_n", {w[4:0], a}, {fr_addr_n, fr_wdata_n});
      if (x) chk("xfer", {w[3:0], m_ptr}, {ctrl_port, ctrl_reg_sel});
      if (x) chk("xfer_n", {w[3:0], m_ptr_n},
         {ctrl_port_n, ctrl_reg_sel_n});
      if (w[11:4] == LIT_PTR_TOP) m_ptr[3:0] = w[3:0];
      if (w == ACC_PTR_OP) m_ptr[4:0] = a[4:0];
      if (w[11:4] == LIT_PTR_TOP) m_ptr_n[3:0] = w[3:0];
      if (w == ACC_PTR_OP) m_ptr_n[3:0] = a[3:0];
      chk("ptr", {5'h0, m_ptr}, {5'h0, ptr});
      chk("ptr_n", {5'h0, m_ptr_n}, {5'h0, ptr_n});
   endtask
   // watchdog
   initial begin
      #(40 * 2000);
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      step(12'h043, 8'h1F);
      step(12'h050, 8'h00);
      for (int f = 4; f < 11; f++) step({8'h00, 4'(f)}, 8'hAA);
      step(12'h03F, 8'hC3);
      $display("corner test done");
      repeat (300) begin
         r = lfsr(r);
         case (r[1:0])
            2'h0: rw = {STORE_ACC_TOP, r[8:4]};
            2'h1: rw = {LIT_PTR_TOP, r[7:4]};
            2'h2: rw = ACC_PTR_OP;
            default: rw = {CTRL_XFER_TOP, r[7:4]};
         endcase
         step(rw, r[15:8]);
      end
      $display("random test done");
      report_and_stop;
   end
endmodule
